// ===== hdl/chsel_defs.vh
/*
 * Constants for the channel sequence select block: register offsets,
 * field positions, reset values and conversion timing.
 * Assumes inclusion by bare name from the design and checker files.
 */
`ifndef CHSEL_DEFS_VH
`define CHSEL_DEFS_VH

// ----------------------------------------------------------------------
// Register map (byte offsets)
// ----------------------------------------------------------------------
`define CHSEL_ADDR_W            4
`define CHSEL_DATA_W            16
`define CHSEL_OFF_CHSEL         4'h0
`define CHSEL_OFF_STATUS        4'h4
`define CHSEL_CHSEL_RST         4'h0

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define CHSEL_STAT_SET_LSB      0
`define CHSEL_STAT_SWMODE_BIT   4
`define CHSEL_STAT_EXTCLK_BIT   5
`define CHSEL_STAT_BUSY_BIT     6
`define CHSEL_STAT_HOLD_BIT     7
`define CHSEL_STAT_STANDBY_N_BIT     8
`define CHSEL_STAT_ACT_LSB      12

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CHSEL_NUM_CH            4
`define CHSEL_CLK_MHZ           20
`define CHSEL_CONV_TIME_NS      2400
`define CHSEL_EXT_CLKS_PER_CONV 16
`define CHSEL_CNT_W             8

`endif

// ===== hdl/chsel_rise_det.v
/*
 * Rising edge detector for one synchronous input.
 * Assumes the input already changes in step with clk.
 */
`timescale 1ns/10ps
module chsel_rise_det #(
    parameter RST_VAL = 1'b1
) (
    input  wire clk,
    input  wire arst_n,
    input  wire level_in,
    output wire rise
);
    reg prev_q;

    // ------------------------------------------------------------------
    // Previous level
    // ------------------------------------------------------------------
    // Reset high so a pin already high at release is no edge
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_q <= RST_VAL;
        end else begin
            prev_q <= level_in;
        end
    end

    assign rise = level_in & ~prev_q;
endmodule // chsel_rise_det

// ===== hdl/chsel_top.v
/*
 * Channel sequence select and conversion sequencer for a four channel
 * simultaneous sampling converter: hardware or software channel set,
 * internal or external conversion clock, standby, channel select register.
 * Assumes all pins are synchronous to clk; the converter core itself,
 * readout path and analog parts are outside.
 */
// Contract
// - In hardware mode the shared clock-input pin is the channel 1 include select.
// - The channel selects are captured at the convert-start rising edge and used for that sequence.
// - In software mode the clock-source pin picks internal (0) or external (1) conversion clock.
// - In hardware mode the shared clock-source pin is the channel 2 include select.
// - In software mode the hardware select pins have no effect.
// - In hardware mode two dedicated pins select channels 3 and 4.
// - A hardware select pin at 1 includes its channel and at 0 excludes it.
// - Mode 0 takes the set from the four pins and always converts on the internal clock.
// - Mode 1 takes the set from the channel select register with internal or external clock.
// - Standby input high is normal operation and low puts the device in standby.
// - A convert-start rising edge holds all four track/holds and starts the selected conversions.
// - A write strobe rising edge with chip select low and read high latches the four low data lines.
// - Register bit 0 enables channel 1 up to bit 3 which enables channel 4.
// - With the external clock each channel conversion takes sixteen of its cycles.
`timescale 1ns/10ps
`include "chsel_defs.vh"

module chsel_top #(
    parameter NUM_CH  = `CHSEL_NUM_CH,
    parameter CLK_MHZ = `CHSEL_CLK_MHZ
) (
    input  wire                        clk,
    input  wire                        arst_n,
    // Control pins
    input  wire                        sw_mode_sel,
    input  wire                        chan1_include_pin,
    input  wire                        clock_source_select,
    input  wire                        chan3_include_pin,
    input  wire                        chan4_include_pin,
    input  wire                        convert_start_n,
    input  wire                        standby_n,
    // Parallel write port
    input  wire                        cs_n,
    input  wire                        rd_n,
    input  wire                        wr_n,
    input  wire                        data_bit_lowest,
    input  wire                        data_bit_second,
    input  wire                        data_bit_third,
    input  wire                        data_bit_fourth,
    // Register port
    input  wire [`CHSEL_ADDR_W-1:0]    reg_addr,
    input  wire [`CHSEL_DATA_W-1:0]    reg_wdata,
    input  wire                        reg_wr,
    input  wire                        reg_rd,
    output reg  [`CHSEL_DATA_W-1:0]    reg_rdata_q,
    // Sequencer outputs
    output reg                         track_hold_q,
    output reg                         busy_q,
    output reg                         conv_done_q,
    output reg  [NUM_CH-1:0]           active_chan_q,
    output reg  [NUM_CH-1:0]           seq_set_q,
    output reg                         sw_mode_q,
    output reg                         ext_clk_q,
    output reg                         standby_q
);

    // ------------------------------------------------------------------
    // Timing constants
    // ------------------------------------------------------------------
    // Least time rounds up to whole cycles
    localparam integer INT_CYCLES_I = (`CHSEL_CONV_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam integer INT_LAST_I   = INT_CYCLES_I - 1;
    localparam integer EXT_LAST_I   = `CHSEL_EXT_CLKS_PER_CONV - 1;
    // Counter holds both end counts; upper bits cut on purpose
    localparam [`CHSEL_CNT_W-1:0] INT_LAST = INT_LAST_I[`CHSEL_CNT_W-1:0];
    localparam [`CHSEL_CNT_W-1:0] EXT_LAST = EXT_LAST_I[`CHSEL_CNT_W-1:0];

    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_CONV = 2'b10;

    reg  [1:0]                state_q;
    reg  [NUM_CH-1:0]         remain_q;
    reg  [`CHSEL_CNT_W-1:0]   cnt_q;
    reg  [NUM_CH-1:0]         chsel_q;

    wire                      start_rise;
    wire                      wr_rise;
    wire                      ext_rise;
    wire [NUM_CH-1:0]         hw_set;
    wire [NUM_CH-1:0]         start_set;
    wire [NUM_CH-1:0]         remain_next;
    wire [NUM_CH-1:0]         pin_data;
    wire                      tick;
    wire [`CHSEL_CNT_W-1:0]   cnt_last;
    wire                      start_ok;
    wire                      bus_wr;
    wire                      pin_wr;
    reg  [`CHSEL_DATA_W-1:0]  status_word;
    reg  [`CHSEL_DATA_W-1:0]  rdata_d;

    function [NUM_CH-1:0] lowest_bit;
        input [NUM_CH-1:0] m;
        begin
            lowest_bit = m & (~m + {{(NUM_CH-1){1'b0}}, 1'b1});
        end
    endfunction

    // ------------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------------
    chsel_rise_det #(
        .RST_VAL  (1'b1)
    ) u_start_det (
        .clk      (clk),
        .arst_n   (arst_n),
        .level_in (convert_start_n),
        .rise     (start_rise)
    );

    chsel_rise_det #(
        .RST_VAL  (1'b1)
    ) u_wr_det (
        .clk      (clk),
        .arst_n   (arst_n),
        .level_in (wr_n),
        .rise     (wr_rise)
    );

    // External clock shares the channel 1 pin
    chsel_rise_det #(
        .RST_VAL  (1'b1)
    ) u_ext_det (
        .clk      (clk),
        .arst_n   (arst_n),
        .level_in (chan1_include_pin),
        .rise     (ext_rise)
    );

    // ------------------------------------------------------------------
    // Selection sources
    // ------------------------------------------------------------------
    // Pin order gives channel 1 in bit 0
    assign hw_set = {chan4_include_pin,
                     chan3_include_pin,
                     clock_source_select,
                     chan1_include_pin};

    // Select pins ignored for the set in software mode
    assign start_set = sw_mode_sel ? chsel_q : hw_set;

    assign pin_data = {data_bit_fourth, data_bit_third,
                       data_bit_second, data_bit_lowest};

    // ------------------------------------------------------------------
    // Write and start decode
    // ------------------------------------------------------------------
    assign bus_wr   = reg_wr & (reg_addr == `CHSEL_OFF_CHSEL);
    // Read high keeps a read cycle from loading stray data
    assign pin_wr   = wr_rise & ~cs_n & rd_n;
    assign start_ok = start_rise & standby_n;

    // ------------------------------------------------------------------
    // Channel select register
    // ------------------------------------------------------------------
    // Bus write wins over a pin write in the same cycle
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chsel_q <= `CHSEL_CHSEL_RST;
        end else if (bus_wr) begin
            chsel_q <= reg_wdata[NUM_CH-1:0];
        end else if (pin_wr) begin
            chsel_q <= pin_data;
        end
    end

    // ------------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------------
    always @* begin
        status_word                                = {`CHSEL_DATA_W{1'b0}};
        status_word[`CHSEL_STAT_SET_LSB +: NUM_CH] = seq_set_q;
        status_word[`CHSEL_STAT_SWMODE_BIT]        = sw_mode_q;
        status_word[`CHSEL_STAT_EXTCLK_BIT]        = ext_clk_q;
        status_word[`CHSEL_STAT_BUSY_BIT]          = busy_q;
        status_word[`CHSEL_STAT_HOLD_BIT]          = track_hold_q;
        status_word[`CHSEL_STAT_STANDBY_N_BIT]          = standby_q;
        status_word[`CHSEL_STAT_ACT_LSB +: NUM_CH] = active_chan_q;
    end

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------
    // Data stands one cycle only, zero otherwise
    always @* begin
        rdata_d = {`CHSEL_DATA_W{1'b0}};
        if (reg_rd) begin
            case (reg_addr)
                `CHSEL_OFF_CHSEL: begin
                    rdata_d[NUM_CH-1:0] = chsel_q;
                end
                `CHSEL_OFF_STATUS: begin
                    rdata_d = status_word;
                end
                default: begin
                    rdata_d = {`CHSEL_DATA_W{1'b0}};
                end
            endcase
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_q <= {`CHSEL_DATA_W{1'b0}};
        end else begin
            reg_rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Standby
    // ------------------------------------------------------------------
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            standby_q <= 1'b0;
        end else begin
            standby_q <= ~standby_n;
        end
    end

    // ------------------------------------------------------------------
    // Conversion timing
    // ------------------------------------------------------------------
    // External clock counted by its rising edges on the shared pin
    assign tick     = ext_clk_q ? ext_rise : 1'b1;
    assign cnt_last = ext_clk_q ? EXT_LAST : INT_LAST;
    assign remain_next = remain_q & ~active_chan_q;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q       <= ST_IDLE;
            remain_q      <= {NUM_CH{1'b0}};
            cnt_q         <= {`CHSEL_CNT_W{1'b0}};
            track_hold_q  <= 1'b0;
            busy_q        <= 1'b0;
            conv_done_q   <= 1'b0;
            active_chan_q <= {NUM_CH{1'b0}};
            seq_set_q     <= {NUM_CH{1'b0}};
            sw_mode_q     <= 1'b0;
            ext_clk_q     <= 1'b0;
        end else begin
            conv_done_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    // Mode, set and clock source frozen together
                    if (start_ok) begin
                        sw_mode_q <= sw_mode_sel;
                        seq_set_q <= start_set;
                        ext_clk_q <= sw_mode_sel & clock_source_select;
                        cnt_q     <= {`CHSEL_CNT_W{1'b0}};
                        if (start_set != {NUM_CH{1'b0}}) begin
                            track_hold_q  <= 1'b1;
                            busy_q        <= 1'b1;
                            remain_q      <= start_set;
                            active_chan_q <= lowest_bit(start_set);
                            state_q       <= ST_CONV;
                        end
                    end
                end
                ST_CONV: begin
                    if (!standby_n) begin
                        // Standby aborts the sequence in flight
                        track_hold_q  <= 1'b0;
                        busy_q        <= 1'b0;
                        remain_q      <= {NUM_CH{1'b0}};
                        active_chan_q <= {NUM_CH{1'b0}};
                        state_q       <= ST_IDLE;
                    end else if (tick) begin
                        if (cnt_q == cnt_last) begin
                            cnt_q       <= {`CHSEL_CNT_W{1'b0}};
                            conv_done_q <= 1'b1;
                            remain_q    <= remain_next;
                            if (remain_next == {NUM_CH{1'b0}}) begin
                                track_hold_q  <= 1'b0;
                                busy_q        <= 1'b0;
                                active_chan_q <= {NUM_CH{1'b0}};
                                state_q       <= ST_IDLE;
                            end else begin
                                active_chan_q <= lowest_bit(remain_next);
                            end
                        end else begin
                            cnt_q <= cnt_q + {{(`CHSEL_CNT_W-1){1'b0}}, 1'b1};
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // chsel_top

// ===== dv/chsel_top_asserts.sv
/* Concurrent checks on the ports of chsel_top, bound below.
   Assumes the defines header is on the include path. */
`timescale 1ns/10ps
`include "chsel_defs.vh"
module chsel_top_asserts #(
    parameter NUM_CH  = `CHSEL_NUM_CH,
    parameter CLK_MHZ = `CHSEL_CLK_MHZ
) (
    input wire              clk,
    input wire              arst_n,
    input wire              sw_mode_sel,
    input wire              chan1_include_pin,
    input wire              clock_source_select,
    input wire              chan3_include_pin,
    input wire              chan4_include_pin,
    input wire              convert_start_n,
    input wire              standby_n,
    input wire              track_hold_q,
    input wire              busy_q,
    input wire              conv_done_q,
    input wire [NUM_CH-1:0] active_chan_q,
    input wire [NUM_CH-1:0] seq_set_q,
    input wire              sw_mode_q,
    input wire              ext_clk_q,
    input wire              standby_q
);
    localparam int INT_CYC = (`CHSEL_CONV_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int EXT_CYC = `CHSEL_EXT_CLKS_PER_CONV;
    logic [7:0] icnt_q;
    logic [7:0] ecnt_q;
    logic       pin1_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ------------------------------------------------------------
    // Per-channel cycle and external edge counters
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            icnt_q <= 8'h0;
            ecnt_q <= 8'h0;
            pin1_q <= 1'b1;
        end else begin
            icnt_q <= (conv_done_q || !busy_q) ? {7'h0, busy_q} : icnt_q + 8'h1;
            ecnt_q <= (conv_done_q || !busy_q) ? 8'h0 : ecnt_q + {7'h0, chan1_include_pin & ~pin1_q};
            pin1_q <= chan1_include_pin;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    sequence s_start;
        !convert_start_n ##1 (convert_start_n && !busy_q && standby_n);
    endsequence
    AST_START_HOLD: assert property (s_start |=> busy_q == (|seq_set_q) && track_hold_q == busy_q
        && active_chan_q == (seq_set_q & (~seq_set_q + 1'b1))) else $error("Start did not hold lowest channel");
    AST_HW_SET: assert property ((s_start ##0 !sw_mode_sel) |=> seq_set_q ==
        {$past(chan4_include_pin), $past(chan3_include_pin), $past(clock_source_select), $past(chan1_include_pin)})
        else $error("Pin set not captured");
    AST_HW_INTCLK: assert property ((s_start ##0 !sw_mode_sel) |=> !sw_mode_q && !ext_clk_q)
        else $error("Hardware mode not on internal clock");
    AST_SW_CLK: assert property ((s_start ##0 sw_mode_sel) |=>
        sw_mode_q && ext_clk_q == $past(clock_source_select)) else $error("Software clock source wrong");
    AST_BUSY_IGNORE: assert property (busy_q && $rose(convert_start_n) |=>
        $stable(seq_set_q) && $stable(sw_mode_q)) else $error("Start taken during a sequence");
    AST_STANDBY_N_FOLLOW: assert property (1'b1 |=> standby_q == !$past(standby_n))
        else $error("Standby flag does not follow input");
    AST_STANDBY_N_ABORT: assert property (busy_q && !standby_n |=> !busy_q && !track_hold_q)
        else $error("Standby did not abort sequence");
    AST_INT_TIME: assert property (conv_done_q && !ext_clk_q |-> icnt_q == INT_CYC)
        else $error("Internal conversion length wrong");
    AST_EXT_COUNT: assert property (conv_done_q && ext_clk_q |-> ecnt_q == EXT_CYC)
        else $error("External clock count wrong");
endmodule // chsel_top_asserts
bind chsel_top chsel_top_asserts #(.NUM_CH(NUM_CH), .CLK_MHZ(CLK_MHZ)) chk_u (.*);

// ===== dv/chsel_host_clk.sv
/* Host-side model: external conversion clock source.
   Assumes the bench holds run from start until busy falls. */
`timescale 1ns/10ps
module chsel_host_clk #(
    parameter HALF = 3
) (
    input  wire clk,
    input  wire arst_n,
    input  wire run,
    output reg  ext_clk_q
);
    reg [3:0] div_q;
    // Well below clk/2 since the design samples this pin
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_q     <= 4'h0;
            ext_clk_q <= 1'b0;
        end else if (!run) begin
            div_q     <= 4'h0;
            ext_clk_q <= 1'b0;
        end else if (div_q == HALF - 1) begin
            div_q     <= 4'h0;
            ext_clk_q <= ~ext_clk_q;
        end else begin
            div_q <= div_q + 4'h1;
        end
    end
endmodule // chsel_host_clk

// ===== dv/chsel_tb.sv
/* Self-checking bench for chsel_top with the host clock model.
   Assumes the design, its header and the checker are compiled first. */
`timescale 1ns/10ps
module testbench;
    reg         clk = 1'b0, arst_n = 1'b0, mode = 1'b0, ch1 = 1'b0, clksel = 1'b0, ch3 = 1'b0, ch4 = 1'b0;
    reg         cst_n = 1'b1, standby_n_n = 1'b1, cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, run = 1'b0;
    reg  [3:0]  db = 4'h0, a = 4'h0, act_p = 4'h0;
    reg  [15:0] wd = 16'h0;
    reg         wr = 1'b0, rd = 1'b0, rd_p = 1'b0;
    reg  [31:0] rs = 32'h00016A87;
    wire        xclk, hold, busy, done, swm, extq, sbq;
    wire [3:0]  act, set;
    wire [15:0] rdata;
    integer     n_mismatch = 0, tests_run = 0, i, k;
    reg  [15:0] exp_rd[$];
    reg  [3:0]  exp_ch[$];
    always #25 clk = ~clk;
    chsel_host_clk host_u (.clk(clk), .arst_n(arst_n), .run(run), .ext_clk_q(xclk));
    chsel_top dut_u (.clk(clk), .arst_n(arst_n), .sw_mode_sel(mode), .chan1_include_pin(mode ? xclk : ch1),
        .clock_source_select(clksel), .chan3_include_pin(ch3), .chan4_include_pin(ch4), .convert_start_n(cst_n),
        .standby_n(standby_n_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .data_bit_lowest(db[0]), .data_bit_second(db[1]),
        .data_bit_third(db[2]), .data_bit_fourth(db[3]), .reg_addr(a), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
        .reg_rdata_q(rdata), .track_hold_q(hold), .busy_q(busy), .conv_done_q(done), .active_chan_q(act),
        .seq_set_q(set), .sw_mode_q(swm), .ext_clk_q(extq), .standby_q(sbq));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function [31:0] rnd(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            rnd = t ^ (t << 5);
        end
    endfunction
    task chk(input [15:0] e, input [15:0] g, input [63:0] nm);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("[FAIL] %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task wreg(input [3:0] ad, input [15:0] d);
        begin
            a <= ad; wd <= d; wr <= 1'b1; @(posedge clk); wr <= 1'b0; @(posedge clk);
        end
    endtask
    task rreg(input [3:0] ad, input [15:0] e);
        begin
            exp_rd.push_back(e); a <= ad; rd <= 1'b1; @(posedge clk); rd <= 1'b0; @(posedge clk);
        end
    endtask
    task pulse;
        begin
            cst_n <= 1'b0; @(posedge clk); cst_n <= 1'b1; @(posedge clk); #1;
        end
    endtask
    // One whole sequence; done pulses are matched by the monitor
    task conv(input [3:0] s, input [15:0] stat);
        begin
            for (k = 0; k < 4; k = k + 1) if (s[k]) exp_ch.push_back(4'h1 << k);
            pulse;
            chk({12'h0, s}, {12'h0, set}, "set");
            chk({15'h0, |s}, {15'h0, hold}, "hold");
            chk({14'h0, stat[4], stat[5]}, {14'h0, swm, extq}, "mode");
            for (k = 0; k < 600 && busy; k = k + 1) begin @(posedge clk); #1; end
            @(posedge clk); @(posedge clk); run <= 1'b0;
            chk(16'h0, exp_ch.size(), "left");
            rreg(4'h4, stat);
        end
    endtask
    // ------------------------------------------------------------
    // Monitor: oldest note against each result
    // ------------------------------------------------------------
    always @(posedge clk) begin
        rd_p <= rd; act_p <= act;
        if (rd_p) chk(exp_rd.pop_front(), rdata, "rdata");
        if (done !== 1'b0) chk({12'h0, exp_ch.pop_front()}, {12'h0, act_p}, "chan");
    end
    task summarize;
        begin
            $display("checks %0d mismatches %0d", tests_run, n_mismatch);
            if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    initial begin
        #2000000; n_mismatch = n_mismatch + 1; summarize;
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1; @(posedge clk);
        rreg(4'h0, 16'h0000); rreg(4'h8, 16'h0000);
        for (i = 0; i < 16; i = i + 1) begin
            {ch4, ch3, clksel, ch1} <= i[3:0];
            conv(i[3:0], {12'h0, i[3:0]});
        end
        mode <= 1'b1;
        for (i = 0; i < 6; i = i + 1) begin
            rs = rnd(rs);
            {ch4, ch3, ch1} <= rs[6:4]; clksel <= i[0];
            wreg(4'h0, rs[15:0]); rreg(4'h0, {12'h0, rs[3:0]});
            run <= i[0];
            conv(rs[3:0], {10'h0, i[0], 1'b1, rs[3:0]});
        end
        clksel <= 1'b0; cs_n <= 1'b0; db <= 4'hA; wr_n <= 1'b0; @(posedge clk);
        wr_n <= 1'b1; @(posedge clk);
        rd_n <= 1'b0; db <= 4'h5; wr_n <= 1'b0; @(posedge clk);
        wr_n <= 1'b1; @(posedge clk);
        cs_n <= 1'b1; rd_n <= 1'b1;
        conv(4'hA, 16'h001A);
        mode <= 1'b0; {ch4, ch3, clksel, ch1} <= 4'hF;
        pulse; @(posedge clk);
        {ch4, ch3, clksel, ch1} <= 4'h3;
        pulse;
        chk(16'h000F, {12'h0, set}, "busy_ign");
        repeat (8) @(posedge clk);
        standby_n_n <= 1'b0; repeat (3) @(posedge clk); #1;
        chk(16'h1, {15'h0, sbq}, "standby");
        chk(16'h0, {15'h0, busy}, "abort");
        @(posedge clk); {ch4, ch3, clksel, ch1} <= 4'h5;
        pulse;
        chk(16'h000F, {12'h0, set}, "blocked");
        @(posedge clk); standby_n_n <= 1'b1; @(posedge clk);
        conv(4'h5, 16'h0005);
        repeat (4) @(posedge clk);
        summarize;
    end
endmodule // testbench
